// [design/idu_top.sv]
// integer divide unit: decode, sign handling, apb registers, writeback
// Functional notes
// - word form 32/16: quotient in low half, remainder in high half.
// - signed remainder takes the sign of the dividend.
// - long 32/32 quotient-only form writes quotient, drops remainder.
// - long 64/32 form from two data registers gives quotient and remainder.
// - long 32/32 form returns both quotient and remainder.
// - zero divisor raises a trap instead of dividing.
// - overflow sets V and leaves destination registers untouched.
// - word form overflows when quotient exceeds a 16-bit signed value.
// - long forms overflow when quotient exceeds a 32-bit signed value.
// - N follows quotient sign; undefined after overflow or zero divide.
// - Z set when quotient is zero; undefined after overflow or trap.
// - V flags overflow, C always cleared, X never changed; a trap or an illegal op leaves C as it was.
// - word-form register field picks one of eight data registers.
// - source must be a data addressing mode; address direct illegal.
// - size bit picks 32-bit or 64-bit dividend.
// - quotient register gives low dividend word and takes quotient.
// - remainder register gets remainder unless it equals quotient one.
// - with size set, remainder register also gives high dividend word.
// - unsigned variants work the same four forms on unsigned values.
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "idu_defs.svh"
module idu_top (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic [7:0] i_paddr,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_wb_q_en,
  output logic [2:0] o_wb_q_sel,
  output logic [31:0] o_wb_q_data,
  output logic o_wb_r_en,
  output logic [2:0] o_wb_r_sel,
  output logic [31:0] o_wb_r_data,
  output logic o_done,
  output logic o_trap,
  output idu_pkg::idu_ccr_t o_ccr
);
  import idu_pkg::*;

  typedef struct packed {
    idu_state_t st;
    logic [15:0] opword;
    logic [15:0] extword;
    logic [31:0] src;
    logic [31:0] dq_val;
    logic [31:0] dr_val;
    idu_ccr_t ccr;
    logic done;
    logic trap;
    logic illegal;
    logic ovf;
    logic [31:0] quot_out;
    logic [31:0] rem_out;
    idu_form_t form;
    logic sgn;
    logic qneg;
    logic rneg;
    logic [2:0] qsel;
    logic [2:0] rsel;
    logic core_start;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic wb_q_en;
    logic wb_r_en;
    logic [31:0] wb_q_data;
    logic [31:0] wb_r_data;
    logic [2:0] wb_q_sel;
    logic [2:0] wb_r_sel;
    logic done_pulse;
    logic trap_pulse;
  } idu_top_t;

  idu_top_t s_reg, s_next;
  logic [1:0] rst_sync_reg;
  logic rst_n;

  // decode of the held instruction words
  logic is_word, is_long, word_sgn, long_sgn, size64;
  logic ea_ok, legal, sgn_d;
  logic [2:0] ea_mode, ea_reg, dq_sel, dr_sel, tgt_sel;
  idu_form_t form_d;
  logic [31:0] divisor;
  logic [63:0] dividend;
  logic sd, ss;
  logic [63:0] ud;
  logic [31:0] uv;

  // result side, from the divider core
  logic core_done;
  logic [63:0] qmag;
  logic [31:0] rmag;
  logic [63:0] qval;
  logic [31:0] rval;
  logic [63:0] lim;
  logic ovf_c, w_form;

  logic acc, wr, rd_hit;
  logic [31:0] rdata;

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_sync_reg <= 2'b00;
    end else if (i_ce) begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  always_comb begin
    ea_mode = s_reg.opword[5:3];
    ea_reg = s_reg.opword[2:0];
    tgt_sel = s_reg.opword[11:9];
    dq_sel = s_reg.extword[14:12];
    dr_sel = s_reg.extword[2:0];
    long_sgn = s_reg.extword[`IDU_EXT_SGN];
    size64 = s_reg.extword[`IDU_EXT_SIZE];
    word_sgn = s_reg.opword[8:6] == `IDU_OP_WORD_SGN;
    is_word = s_reg.opword[15:12] == `IDU_OP_WORD_TOP &&
      (word_sgn || s_reg.opword[8:6] == `IDU_OP_WORD_UNS);
    is_long = s_reg.opword[15:6] == `IDU_OP_LONG &&
      !s_reg.extword[15] && s_reg.extword[9:3] == 7'h00;
    // address-register direct and pc/absolute beyond immediate refused
    ea_ok = ea_mode != `IDU_EA_AREG &&
      (ea_mode != `IDU_EA_EXT || ea_reg <= `IDU_EA_EXT_MAX);
    legal = ea_ok && (is_word || is_long);
    sgn_d = is_word ? word_sgn : long_sgn;
    if (is_word) begin
      form_d = IDU_F_WORD;
    end else if (size64) begin
      form_d = IDU_F_L64;
    end else if (dq_sel == dr_sel) begin
      form_d = IDU_F_L32Q;
    end else begin
      form_d = IDU_F_L32R;
    end
    if (is_word) begin
      divisor = sgn_d ? {{16{s_reg.src[15]}}, s_reg.src[15:0]} :
        {16'h0000, s_reg.src[15:0]};
    end else begin
      divisor = s_reg.src;
    end
    if (form_d == IDU_F_L64) begin
      dividend = {s_reg.dr_val, s_reg.dq_val};
    end else begin
      dividend = sgn_d ? {{32{s_reg.dq_val[31]}}, s_reg.dq_val} :
        {32'h0000_0000, s_reg.dq_val};
    end
    sd = sgn_d && dividend[63];
    ss = sgn_d && divisor[31];
    ud = sd ? 64'(-dividend) : dividend;
    uv = ss ? 32'(-divisor) : divisor;
  end

  // overflow, sign restore and flag formation on the finished magnitudes
  always_comb begin
    w_form = s_reg.form == IDU_F_WORD;
    lim = w_form ? 64'h0000_0000_0000_8000 : 64'h0000_0000_8000_0000;
    if (!s_reg.sgn) begin
      ovf_c = qmag >= (lim << 1);
    end else if (s_reg.qneg) begin
      ovf_c = qmag > lim;
    end else begin
      ovf_c = qmag >= lim;
    end
    qval = s_reg.qneg ? 64'(-qmag) : qmag;
    rval = s_reg.rneg ? 32'(-rmag) : rmag;
  end

  idu_divcore #(
    .N_W(64),
    .D_W(32)
  ) u_core (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(rst_n),
    .i_ce(i_ce),
    .i_start(s_reg.core_start),
    .i_dividend(ud),
    .i_divisor(uv),
    .o_done(core_done),
    .o_quot(qmag),
    .o_rem(rmag)
  );

  // apb: one wait state, write takes effect on the ready edge, read data is latched on the edge before it
  always_comb begin
    acc = i_psel && i_penable;
    wr = acc && s_reg.pready && i_pwrite;
    rd_hit = 1'b1;
    case (i_paddr)
      `IDU_OFF_OPWORD: rdata = {16'h0000, s_reg.opword};
      `IDU_OFF_EXTWORD: rdata = {16'h0000, s_reg.extword};
      `IDU_OFF_SRC: rdata = s_reg.src;
      `IDU_OFF_DQVAL: rdata = s_reg.dq_val;
      `IDU_OFF_DRVAL: rdata = s_reg.dr_val;
      `IDU_OFF_CTRL: rdata = `IDU_DATA_RST;
      `IDU_OFF_STATUS: rdata = {27'h000_0000, s_reg.ovf, s_reg.illegal,
        s_reg.trap, s_reg.done, s_reg.st != IDU_S_IDLE};
      `IDU_OFF_QUOT: rdata = s_reg.quot_out;
      `IDU_OFF_REM: rdata = s_reg.rem_out;
      `IDU_OFF_CCR: rdata = {27'h000_0000, s_reg.ccr};
      default: begin
        rdata = `IDU_DATA_RST;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    s_next = s_reg;
    s_next.pready = acc && !s_reg.pready;
    s_next.pslverr = acc && !s_reg.pready && !rd_hit;
    if (acc && !s_reg.pready) begin
      s_next.prdata = rdata;
    end
    s_next.core_start = 1'b0;
    s_next.wb_q_en = 1'b0;
    s_next.wb_r_en = 1'b0;
    s_next.done_pulse = 1'b0;
    s_next.trap_pulse = 1'b0;
    if (wr) begin
      case (i_paddr)
        `IDU_OFF_OPWORD: s_next.opword = i_pwdata[15:0];
        `IDU_OFF_EXTWORD: s_next.extword = i_pwdata[15:0];
        `IDU_OFF_SRC: s_next.src = i_pwdata;
        `IDU_OFF_DQVAL: s_next.dq_val = i_pwdata;
        `IDU_OFF_DRVAL: s_next.dr_val = i_pwdata;
        `IDU_OFF_CCR: s_next.ccr = i_pwdata[4:0];
        default: begin
        end
      endcase
    end
    case (s_reg.st)
      IDU_S_IDLE: begin
        // start while busy is ignored; the core latches its operands
        if (wr && i_paddr == `IDU_OFF_CTRL &&
            i_pwdata[`IDU_CTRL_START]) begin
          s_next.done = 1'b0;
          s_next.trap = 1'b0;
          s_next.illegal = 1'b0;
          s_next.ovf = 1'b0;
          s_next.form = form_d;
          s_next.sgn = sgn_d;
          s_next.qneg = sd ^ ss;
          s_next.rneg = sd;
          s_next.qsel = is_word ? tgt_sel : dq_sel;
          s_next.rsel = dr_sel;
          if (!legal) begin
            s_next.illegal = 1'b1;
            s_next.done = 1'b1;
            s_next.done_pulse = 1'b1;
          end else if (divisor == `IDU_DATA_RST) begin
            // trap: no writes, flags left as they were
            s_next.trap = 1'b1;
            s_next.trap_pulse = 1'b1;
            s_next.done = 1'b1;
            s_next.done_pulse = 1'b1;
          end else begin
            s_next.core_start = 1'b1;
            s_next.st = IDU_S_DIV;
          end
        end
      end
      IDU_S_DIV: begin
        if (core_done) begin
          s_next.st = IDU_S_COMMIT;
        end
      end
      IDU_S_COMMIT: begin
        // all results and flags land together
        s_next.st = IDU_S_IDLE;
        s_next.done = 1'b1;
        s_next.done_pulse = 1'b1;
        s_next.ccr.c = 1'b0;
        s_next.ccr.v = ovf_c;
        s_next.ovf = ovf_c;
        s_next.quot_out = qval[31:0];
        s_next.rem_out = rval;
        if (ovf_c) begin
          // operands stay put; N and Z cleared for determinism
          s_next.ccr.n = 1'b0;
          s_next.ccr.z = 1'b0;
        end else if (w_form) begin
          s_next.ccr.n = qval[15];
          s_next.ccr.z = qval[15:0] == 16'h0000;
          s_next.wb_q_en = 1'b1;
          s_next.wb_q_sel = s_reg.qsel;
          s_next.wb_q_data = {rval[15:0], qval[15:0]};
        end else begin
          s_next.ccr.n = qval[31];
          s_next.ccr.z = qval[31:0] == `IDU_DATA_RST;
          s_next.wb_q_en = 1'b1;
          s_next.wb_q_sel = s_reg.qsel;
          s_next.wb_q_data = qval[31:0];
          s_next.wb_r_en = s_reg.form != IDU_F_L32Q &&
            s_reg.rsel != s_reg.qsel;
          s_next.wb_r_sel = s_reg.rsel;
          s_next.wb_r_data = rval;
        end
      end
      default: begin
        s_next.st = IDU_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.ccr <= `IDU_CCR_RST;
      s_reg.opword <= `IDU_WORD_RST;
      s_reg.extword <= `IDU_WORD_RST;
    end else if (i_ce) begin
      s_reg <= s_next;
    end
  end

  assign o_prdata = s_reg.prdata;
  assign o_pready = s_reg.pready;
  assign o_pslverr = s_reg.pslverr;
  assign o_wb_q_en = s_reg.wb_q_en;
  assign o_wb_q_sel = s_reg.wb_q_sel;
  assign o_wb_q_data = s_reg.wb_q_data;
  assign o_wb_r_en = s_reg.wb_r_en;
  assign o_wb_r_sel = s_reg.wb_r_sel;
  assign o_wb_r_data = s_reg.wb_r_data;
  assign o_done = s_reg.done_pulse;
  assign o_trap = s_reg.trap_pulse;
  assign o_ccr = s_reg.ccr;
endmodule
`default_nettype wire

// [design/idu_defs.svh]
// register map, field positions and reset values of the divide unit
`ifndef IDU_DEFS_SVH
`define IDU_DEFS_SVH
`define IDU_OFF_OPWORD 8'h00
`define IDU_OFF_EXTWORD 8'h04
`define IDU_OFF_SRC 8'h08
`define IDU_OFF_DQVAL 8'h0c
`define IDU_OFF_DRVAL 8'h10
`define IDU_OFF_CTRL 8'h14
`define IDU_OFF_STATUS 8'h18
`define IDU_OFF_QUOT 8'h1c
`define IDU_OFF_REM 8'h20
`define IDU_OFF_CCR 8'h24
`define IDU_CTRL_START 0
`define IDU_ST_BUSY 0
`define IDU_ST_DONE 1
`define IDU_ST_TRAP 2
`define IDU_ST_ILLEGAL 3
`define IDU_ST_OVF 4
`define IDU_CCR_RST 5'h00
`define IDU_WORD_RST 16'h0000
`define IDU_DATA_RST 32'h0000_0000
`define IDU_OP_WORD_TOP 4'h8
`define IDU_OP_WORD_SGN 3'h7
`define IDU_OP_WORD_UNS 3'h3
`define IDU_OP_LONG 10'h131
`define IDU_EXT_SGN 11
`define IDU_EXT_SIZE 10
`define IDU_EA_AREG 3'h1
`define IDU_EA_EXT 3'h7
`define IDU_EA_EXT_MAX 3'h4
`define IDU_DIV_STEPS 64
`endif

// [design/idu_pkg.sv]
// types shared by the divide unit files
package idu_pkg;
  typedef enum logic [1:0] {
    IDU_S_IDLE = 2'b00,
    IDU_S_DIV = 2'b01,
    IDU_S_COMMIT = 2'b10
  } idu_state_t;
  typedef enum logic [1:0] {
    IDU_F_WORD = 2'b00,
    IDU_F_L32Q = 2'b01,
    IDU_F_L64 = 2'b10,
    IDU_F_L32R = 2'b11
  } idu_form_t;
  typedef struct packed {
    logic x;
    logic n;
    logic z;
    logic v;
    logic c;
  } idu_ccr_t;
endpackage

// [design/idu_divcore.sv]
// iterative unsigned restoring divider, one quotient bit per cycle
`timescale 1ns/1ns
`default_nettype none
module idu_divcore #(
  parameter int N_W = 64,
  parameter int D_W = 32
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_start,
  input wire logic [N_W-1:0] i_dividend,
  input wire logic [D_W-1:0] i_divisor,
  output logic o_done,
  output logic [N_W-1:0] o_quot,
  output logic [D_W-1:0] o_rem
);
  import idu_pkg::*;
  localparam int CW = $clog2(N_W + 1);
  typedef struct packed {
    logic busy;
    logic done;
    logic [CW-1:0] cnt;
    logic [N_W-1:0] quot;
    logic [D_W-1:0] rem;
    logic [D_W-1:0] dvs;
  } idu_core_t;
  idu_core_t s_reg, s_next;
  logic [D_W:0] trial;

  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    trial = {s_reg.rem, s_reg.quot[N_W-1]};
    if (i_start && !s_reg.busy) begin
      s_next.busy = 1'b1;
      s_next.cnt = CW'(N_W);
      s_next.quot = i_dividend;
      s_next.rem = '0;
      s_next.dvs = i_divisor;
    end else if (s_reg.busy) begin
      s_next.quot = {s_reg.quot[N_W-2:0], 1'b0};
      if (trial >= {1'b0, s_reg.dvs}) begin
        s_next.rem = D_W'(trial - {1'b0, s_reg.dvs});
        s_next.quot[0] = 1'b1;
      end else begin
        s_next.rem = trial[D_W-1:0];
      end
      s_next.cnt = s_reg.cnt - CW'(1);
      if (s_reg.cnt == CW'(1)) begin
        s_next.busy = 1'b0;
        s_next.done = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_reg <= '0;
    end else if (i_ce) begin
      s_reg <= s_next;
    end
  end

  assign o_done = s_reg.done;
  assign o_quot = s_reg.quot;
  assign o_rem = s_reg.rem;
endmodule
`default_nettype wire

// [tb/idu_monitor.sv]
// concurrent checks on the divide unit ports
`timescale 1ns/1ns
`default_nettype none
`include "idu_defs.svh"
module idu_monitor (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic [7:0] i_paddr,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_pwdata,
  input wire logic o_pready,
  input wire logic o_wb_q_en,
  input wire logic [2:0] o_wb_q_sel,
  input wire logic [31:0] o_wb_q_data,
  input wire logic o_wb_r_en,
  input wire logic [2:0] o_wb_r_sel,
  input wire logic o_done,
  input wire logic o_trap,
  input wire idu_pkg::idu_ccr_t o_ccr
);
  import idu_pkg::*;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  logic start_evt;
  assign start_evt = i_psel && i_penable && o_pready && i_pwrite &&
    i_paddr == `IDU_OFF_CTRL && i_pwdata[0];
  trap_no_write_a: assert property (
    o_trap |-> o_done && !o_wb_q_en && !o_wb_r_en) else $error("trap wrote");
  trap_single_a: assert property (
    o_trap |=> !o_trap) else $error("trap held");
  trap_latency_a: assert property (
    o_trap |-> $past(start_evt, 1) || $past(start_evt, 2))
    else $error("trap timing");
  carry_clear_a: assert property (
    o_wb_q_en |-> !o_ccr.c) else $error("carry set");
  extend_kept_a: assert property (
    o_done |-> o_ccr.x == $past(o_ccr.x)) else $error("extend changed");
  no_ovf_write_a: assert property (
    o_wb_q_en |-> !o_ccr.v) else $error("write on overflow");
  rem_pair_a: assert property (
    o_wb_r_en |-> o_wb_q_en && o_wb_r_sel != o_wb_q_sel)
    else $error("remainder write bad");
  neg_flag_a: assert property (
    o_wb_r_en |-> o_ccr.n == o_wb_q_data[31]) else $error("n flag");
  zero_flag_a: assert property (
    o_wb_r_en |-> o_ccr.z == (o_wb_q_data == 32'h0000_0000))
    else $error("z flag");
  commit_time_a: assert property (
    o_wb_q_en |-> $past(start_evt, 67) || $past(start_evt, 68))
    else $error("commit timing");
  commit_once_a: assert property (
    o_wb_q_en |=> !o_wb_q_en && !o_done) else $error("commit repeated");
endmodule
bind idu_top idu_monitor i_mon (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
  .i_paddr(i_paddr), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_pwdata(i_pwdata), .o_pready(o_pready),
  .o_wb_q_en(o_wb_q_en), .o_wb_q_sel(o_wb_q_sel),
  .o_wb_q_data(o_wb_q_data), .o_wb_r_en(o_wb_r_en),
  .o_wb_r_sel(o_wb_r_sel), .o_done(o_done), .o_trap(o_trap), .o_ccr(o_ccr));
`default_nettype wire

// [tb/idu_regfile_model.sv]
// data register file beside the divide unit, applies writebacks
`timescale 1ns/1ns
`default_nettype none
module idu_regfile_model (
  input wire logic i_clk_sys,
  input wire logic i_wb_q_en,
  input wire logic [2:0] i_wb_q_sel,
  input wire logic [31:0] i_wb_q_data,
  input wire logic i_wb_r_en,
  input wire logic [2:0] i_wb_r_sel,
  input wire logic [31:0] i_wb_r_data,
  output logic [31:0] o_dreg [8],
  output int o_nwr
);
  // write count lets the bench see refused operations touch nothing
  initial o_nwr = 0;
  always @(posedge i_clk_sys) begin
    o_nwr <= o_nwr + int'(i_wb_q_en) + int'(i_wb_r_en);
    if (i_wb_q_en) begin
      o_dreg[i_wb_q_sel] <= i_wb_q_data;
    end
    if (i_wb_r_en) begin
      o_dreg[i_wb_r_sel] <= i_wb_r_data;
    end
  end
endmodule
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the divide unit over apb
`timescale 1ns/1ns
`default_nettype none
`include "idu_defs.svh"
module tb;
  import idu_pkg::*;
  logic clk = 0;
  logic rstn = 0;
  logic psel = 0;
  logic pen = 0;
  logic pwr = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, wbqd, wbrd, rd;
  logic pready, pslverr, wbqe, wbre, done, trap, err, trap_seen, ill;
  logic [2:0] wbqs, wbrs, md, rg;
  idu_ccr_t ccr;
  logic [31:0] dreg [8];
  int nwr, w0;
  int failures = 0;
  int checks_done = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  idu_top i_dut (.i_clk_sys(clk), .i_resetn(rstn), .i_ce(1'b1),
    .i_paddr(paddr), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_wb_q_en(wbqe), .o_wb_q_sel(wbqs),
    .o_wb_q_data(wbqd), .o_wb_r_en(wbre), .o_wb_r_sel(wbrs),
    .o_wb_r_data(wbrd), .o_done(done), .o_trap(trap), .o_ccr(ccr));
  idu_regfile_model i_rf (.i_clk_sys(clk), .i_wb_q_en(wbqe),
    .i_wb_q_sel(wbqs), .i_wb_q_data(wbqd), .i_wb_r_en(wbre),
    .i_wb_r_sel(wbrs), .i_wb_r_data(wbrd), .o_dreg(dreg), .o_nwr(nwr));
  task automatic final_report();
    if (failures == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      final_report();
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s exp %h seen %h", nm, e, s);
    end
  endtask
  // idle edge first, so psel is never assigned twice in one step
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // operands are not touched again until done, though the core latches them
  task automatic op(input logic [15:0] ow, ew, input logic [31:0] s, q, r);
    apb(1'b1, `IDU_OFF_OPWORD, {16'h0000, ow});
    apb(1'b1, `IDU_OFF_EXTWORD, {16'h0000, ew});
    apb(1'b1, `IDU_OFF_SRC, s);
    apb(1'b1, `IDU_OFF_DQVAL, q);
    apb(1'b1, `IDU_OFF_DRVAL, r);
    w0 = nwr;
    apb(1'b1, `IDU_OFF_CTRL, 32'h0000_0001);
    do @(posedge clk); while (done !== 1'b1);
    trap_seen = trap;
    @(posedge clk);
  endtask
  task automatic res(input int nw, input logic [31:0] c);
    chk("writes", 32'(nwr - w0), 32'(nw));
    chk("ccr", 32'(ccr), c);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    op(16'h8bc1, 16'h0000, 32'h0000_0002, 32'hffff_fff9, 32'h0000_0000);
    chk("dreg5", dreg[5], 32'hffff_fffd);
    res(1, 32'h0000_0008);
    op(16'h84fc, 16'h0000, 32'h0000_0010, 32'h0001_0005, 32'h0000_0000);
    chk("dreg2", dreg[2], 32'h0005_1000);
    op(16'h8bc1, 16'h0000, 32'h0000_0005, 32'h0000_0001, 32'h0000_0000);
    res(1, 32'h0000_0004);
    op(16'h8bc1, 16'h0000, 32'h0000_0001, 32'hffff_8000, 32'h0000_0000);
    chk("dreg5", dreg[5], 32'h0000_8000);
    op(16'h8bc1, 16'h0000, 32'h0000_0001, 32'h0000_8000, 32'h0000_0000);
    res(0, 32'h0000_0002);
    chk("dreg5", dreg[5], 32'h0000_8000);
    op(16'h8bc1, 16'h0000, 32'h0000_0000, 32'h0000_0009, 32'h0000_0000);
    chk("trap", 32'(trap_seen), 32'h0000_0001);
    res(0, 32'h0000_0002);
    op(16'h4c41, 16'h3803, 32'h0000_0007, 32'hffff_ff9c, 32'h0000_0000);
    chk("dreg3", dreg[3], 32'hffff_fff2);
    res(1, 32'h0000_0008);
    op(16'h4c41, 16'h3804, 32'h0000_0002, 32'hffff_fff9, 32'h0000_0000);
    chk("dreg4", dreg[4], 32'hffff_ffff);
    res(2, 32'h0000_0008);
    apb(1'b0, `IDU_OFF_QUOT, 32'h0000_0000);
    chk("quot", rd, 32'hffff_fffd);
    apb(1'b0, `IDU_OFF_REM, 32'h0000_0000);
    chk("rem", rd, 32'hffff_ffff);
    op(16'h4c41, 16'h1406, 32'h0000_0002, 32'h0000_0003, 32'h0000_0001);
    chk("dreg1", dreg[1], 32'h8000_0001);
    chk("dreg6", dreg[6], 32'h0000_0001);
    op(16'h4c41, 16'h1c06, 32'h0000_0001, 32'h0000_0000, 32'h0000_0001);
    res(0, 32'h0000_0002);
    apb(1'b1, `IDU_OFF_CCR, 32'h0000_0011);
    op(16'h4c41, 16'h0007, 32'h0000_0010, 32'hffff_fff0, 32'h0000_0000);
    chk("dreg0", dreg[0], 32'h0fff_ffff);
    res(2, 32'h0000_0010);
    for (int i = 0; i < 16; i++) begin
      md = (i < 8) ? 3'(i) : 3'h7;
      rg = (i < 8) ? 3'h4 : 3'(i - 8);
      ill = (md == 3'h1) || (md == 3'h7 && rg > 3'h4);
      op(16'h81c0 | {10'h000, md, rg}, 16'h0000, 32'h0000_0001,
        32'h0000_0003, 32'h0000_0000);
      chk("writes", 32'(nwr - w0), 32'(!ill));
      apb(1'b0, `IDU_OFF_STATUS, 32'h0000_0000);
      chk("illegal", 32'(rd[3]), 32'(ill));
    end
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk("slverr", 32'(err), 32'h0000_0001);
    final_report();
  end
endmodule
`default_nettype wire
